// file: core/fcc_host.sv
/*
  Host controller for the flash charger: drives the charge request and
  the two flash inputs, watches the open-drain completion indicator and
  times each charge to find an overcurrent trip.
  Assumes the completion indicator carries an external pull-up and that
  all pin inputs are synchronous to aclk.
*/
// Design decisions made here: the AXI4-Lite interface to the registers and the address map.
//
// Contract
// RULE1: Charging starts only on high charge request.
// RULE2: Device delays internal enable after request edge.
// RULE3: Switch starts no sooner than enable delay.
// RULE4: Low charge request forces immediate stop.
// RULE5: Full threshold stops charging, indicator low.
// RULE6: Overcurrent also stops charging.
// RULE7: Host may raise request again to restart.
// RULE8: Completion pulls open-drain indicator low.
// RULE9: Indicator stays low until request drops.
// RULE10: Indicator high impedance while charging or faulted.
// RULE11: Host flags fault when charge time exceeded.
// RULE12: Switch off above peak current.
// RULE13: Switch on when kickback falls below zero.
// RULE14: Gate high only when permit and trigger.
// RULE15: Host may drive permit and trigger together.
// RULE16: Gate follows flash inputs after 25 ns.
// RULE17: Thermal trip latches off until request low.
// RULE18: Overcurrent during on-time latches charger off.
// RULE19: Overcurrent latch clears after request low.
// RULE20: Switch toggles only when enabled, unlatched.
// RULE21: Flash gate independent of charging state.
`timescale 1ns/1ps
module fcc_host
  import fcc_pkg::*;
#(
  parameter int CHARGE_TIMEOUT = CHARGE_TIMEOUT_DEF
) (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write
  input  wire logic [3:0]  s_axil_awaddr,
  input  wire logic        s_axil_awvalid,
  output logic             s_axil_awready,
  input  wire logic [31:0] s_axil_wdata,
  input  wire logic [3:0]  s_axil_wstrb,
  input  wire logic        s_axil_wvalid,
  output logic             s_axil_wready,
  output logic [1:0]       s_axil_bresp,
  output logic             s_axil_bvalid,
  input  wire logic        s_axil_bready,
  // AXI4-Lite read
  input  wire logic [3:0]  s_axil_araddr,
  input  wire logic        s_axil_arvalid,
  output logic             s_axil_arready,
  output logic [31:0]      s_axil_rdata,
  output logic [1:0]       s_axil_rresp,
  output logic             s_axil_rvalid,
  input  wire logic        s_axil_rready,
  // Device pins
  output fcc_pins_t        pins,
  input  wire logic        charge_done_n,
  input  wire logic        flash_gate_drive
);

  fcc_state_t  state;
  fcc_state_t  next_state;
  logic [3:0]  control;
  logic [31:0] timeout;
  logic [31:0] elapsed;
  logic [31:0] status;
  logic        fault;
  logic        want_charge;
  logic        want_permit;
  logic        want_trigger;
  logic        gate_expect;
  logic        gate_mismatch;
  logic [31:0] low_count;

  // ---------------------------------------------------------------------
  // Register bus
  // ---------------------------------------------------------------------
  fcc_axil_slave u_regs (
    .aclk    (aclk),
    .aresetn (aresetn),
    .awaddr  (s_axil_awaddr),
    .awvalid (s_axil_awvalid),
    .awready (s_axil_awready),
    .wdata   (s_axil_wdata),
    .wstrb   (s_axil_wstrb),
    .wvalid  (s_axil_wvalid),
    .wready  (s_axil_wready),
    .bresp   (s_axil_bresp),
    .bvalid  (s_axil_bvalid),
    .bready  (s_axil_bready),
    .araddr  (s_axil_araddr),
    .arvalid (s_axil_arvalid),
    .arready (s_axil_arready),
    .rdata   (s_axil_rdata),
    .rresp   (s_axil_rresp),
    .rvalid  (s_axil_rvalid),
    .rready  (s_axil_rready),
    .control (control),
    .timeout (timeout),
    .status  (status),
    .elapsed (elapsed)
  );

  assign want_charge  = control[CTL_CHARGE];
  assign want_permit  = control[CTL_PERMIT];
  // In linked mode one bit drives both flash inputs as a single signal.
  // RULE15: linked flash inputs
  assign want_trigger = control[CTL_LINKED] ? control[CTL_PERMIT]
                                            : control[CTL_TRIGGER];

  // ---------------------------------------------------------------------
  // Charge sequencer
  // ---------------------------------------------------------------------
  // Next state from the software request, the completion indicator and the charge timer.
  always_comb
  begin
    next_state = state;
    case (state)
      FCC_IDLE:
        // RULE1: start on request
        if (want_charge) next_state = FCC_RUN;
      FCC_RUN:
        // RULE4: software stop drops request
        if (!want_charge) next_state = FCC_IDLE;
        // RULE8: indicator low means full
        else if (!charge_done_n) next_state = FCC_DONE;
        // RULE11: charge took too long
        else if (elapsed >= CHARGE_TIMEOUT - 1) next_state = FCC_FAULT;
      // RULE9: stays done until request is dropped
      FCC_DONE:  if (!want_charge) next_state = FCC_IDLE;
      // RULE19: a fault clears only through a low request
      FCC_FAULT: if (!want_charge) next_state = FCC_IDLE;
      default:   next_state = FCC_IDLE;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      state <= FCC_IDLE;
    else
      state <= next_state;
  end

  // Request pin is high while running, done or faulted; leaving done or fault passes
  // through idle so the device always sees a low level before a restart.
  // RULE7: restart after forced low
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pins.charge_request <= 1'b0;
    else
      pins.charge_request <= (next_state == FCC_RUN) ||
                             (next_state == FCC_DONE) ||
                             (next_state == FCC_FAULT && want_charge);
  end

  // Charge timer counts from the request rising while running.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      elapsed <= 32'h0;
    else if (state == FCC_IDLE)
      elapsed <= 32'h0;
    else if (state == FCC_RUN)
      elapsed <= elapsed + 32'h1;
  end

  // Fault flag is sticky until software drops the charge request.
  // RULE17: latched-off trip seen as timeout
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      fault <= 1'b0;
    else if (next_state == FCC_FAULT)
      fault <= 1'b1;
    else if (next_state == FCC_IDLE)
      fault <= 1'b0;
  end

  // ---------------------------------------------------------------------
  // Flash inputs
  // ---------------------------------------------------------------------
  // Flash pins are driven apart from the charge sequencer.
  // RULE21: flash independent of charging
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pins.flash_permit  <= 1'b0;
      pins.flash_trigger <= 1'b0;
    end
    else
    begin
      pins.flash_permit  <= want_permit;
      pins.flash_trigger <= want_trigger;
    end
  end

  // Expected gate level lags the pins by the device propagation time.
  // RULE16: gate follows after delay
  fcc_delay_line #(
    .DEPTH (GATE_PROP_CYC)
  ) u_gate_delay (
    .aclk    (aclk),
    .aresetn (aresetn),
    .din     (pins.flash_permit & pins.flash_trigger),
    .dout    (gate_expect)
  );

  // Mismatch is sticky; it only reports, it never stops the flash.
  // RULE14: gate equals permit and trigger
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      gate_mismatch <= 1'b0;
    else if (flash_gate_drive != gate_expect)
      gate_mismatch <= 1'b1;
  end

  // Status word returned to software.
  assign status = {26'h0, state, gate_mismatch, pins.charge_request,
                   fault, (state == FCC_DONE)};

  // ---------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------
  // Counts how long the request has been held low, for the checks.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      low_count <= 32'h0;
    else if (pins.charge_request)
      low_count <= 32'h0;
    else if (low_count != 32'hffffffff)
      low_count <= low_count + 32'h1;
  end

  // RULE1: rise needs software
  AST_START_ON_REQ: assert property ( // RULE1
    @(posedge aclk) disable iff (!aresetn)
    $rose(pins.charge_request) |-> $past(want_charge))
    else $error("Charge request rose without software request.");

  // RULE4: stop drops the pin
  AST_STOP_FORCED: assert property ( // RULE4
    @(posedge aclk) disable iff (!aresetn)
    !want_charge |=> !pins.charge_request)
    else $error("Charge request not dropped after stop.");

  // RULE4: low pin means idle
  AST_LOW_MEANS_IDLE: assert property ( // RULE4
    @(posedge aclk) disable iff (!aresetn)
    !pins.charge_request |-> state == FCC_IDLE)
    else $error("Sequencer busy while charge request is low.");

  // RULE7: low seen before restart
  AST_LOW_BEFORE_RISE: assert property ( // RULE7
    @(posedge aclk) disable iff (!aresetn)
    $rose(pins.charge_request) |-> low_count != 32'h0)
    else $error("Charge request rose with no low level before it.");

  // RULE7: idle request restarts
  AST_RESTART: assert property ( // RULE7
    @(posedge aclk) disable iff (!aresetn)
    (state == FCC_IDLE) && want_charge |=> pins.charge_request)
    else $error("Restart did not raise charge request.");

  // RULE8: low indicator ends run
  AST_DONE_ON_LOW: assert property ( // RULE8
    @(posedge aclk) disable iff (!aresetn)
    (state == FCC_RUN) && want_charge && !charge_done_n |=>
    state == FCC_DONE)
    else $error("Low completion indicator did not end the run.");

  // RULE9: done holds with request
  AST_DONE_HOLDS: assert property ( // RULE9
    @(posedge aclk) disable iff (!aresetn)
    (state == FCC_DONE) && want_charge |=> state == FCC_DONE)
    else $error("Done state left while request still high.");

  // RULE11: timeout raises fault
  AST_FAULT_TIME: assert property ( // RULE11
    @(posedge aclk) disable iff (!aresetn)
    (state == FCC_RUN) && want_charge && charge_done_n &&
    (elapsed >= CHARGE_TIMEOUT - 1) |=> fault)
    else $error("Charge timeout did not raise fault.");

  // RULE11: timer starts from zero
  AST_TIMER_CLEAR: assert property ( // RULE11
    @(posedge aclk) disable iff (!aresetn)
    state == FCC_IDLE |=> elapsed == 32'h0)
    else $error("Charge timer not cleared while idle.");

  // RULE19: fault clears on low request
  AST_FAULT_CLEAR: assert property ( // RULE19
    @(posedge aclk) disable iff (!aresetn)
    $fell(fault) |-> !want_charge || $past(!want_charge))
    else $error("Fault cleared without request drop.");

  // RULE19: pin stays high in fault
  AST_FAULT_PIN_HIGH: assert property ( // RULE19
    @(posedge aclk) disable iff (!aresetn)
    state == FCC_FAULT |-> pins.charge_request)
    else $error("Charge request low while fault is held.");

  // RULE15: linked trigger copies permit
  AST_LINKED: assert property ( // RULE15
    @(posedge aclk) disable iff (!aresetn)
    control[CTL_LINKED] |=> pins.flash_trigger == $past(control[CTL_PERMIT]))
    else $error("Linked flash inputs differ.");

  // RULE15: unlinked trigger stands alone
  AST_UNLINKED: assert property ( // RULE15
    @(posedge aclk) disable iff (!aresetn)
    !control[CTL_LINKED] |=>
    pins.flash_trigger == $past(control[CTL_TRIGGER]))
    else $error("Unlinked flash trigger did not follow software.");

  // RULE21: permit follows software
  AST_FLASH_FREE: assert property ( // RULE21
    @(posedge aclk) disable iff (!aresetn)
    ##1 pins.flash_permit == $past(want_permit))
    else $error("Flash permit did not follow software.");

endmodule : fcc_host

// file: core/fcc_pkg.sv
/*
  Package for the flash charger host controller: register offsets,
  field positions, reset values, timing constants, state and carrier types.
  Assumes a 200 MHz system clock and a 32-bit AXI4-Lite register bus.
*/
package fcc_pkg;

  // ---------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------
  localparam int CLK_PERIOD_PS      = 5000;
  localparam int ENABLE_DELAY_NS    = 150;
  localparam int ENABLE_DELAY_CYC   = (ENABLE_DELAY_NS * 1000) / CLK_PERIOD_PS;
  localparam int GATE_PROP_NS       = 25;
  localparam int GATE_PROP_CYC      = (GATE_PROP_NS * 1000) / CLK_PERIOD_PS;
  localparam int CHARGE_TIMEOUT_DEF = 40000000;

  // ---------------------------------------------------------------------
  // Register map (byte offsets)
  // ---------------------------------------------------------------------
  localparam logic [3:0] REG_CONTROL = 4'h0;
  localparam logic [3:0] REG_STATUS  = 4'h4;
  localparam logic [3:0] REG_TIMEOUT = 4'h8;
  localparam logic [3:0] REG_ELAPSED = 4'hc;

  // Control fields.
  localparam int CTL_CHARGE  = 0;
  localparam int CTL_PERMIT  = 1;
  localparam int CTL_TRIGGER = 2;
  localparam int CTL_LINKED  = 3;

  // Status fields.
  localparam int STS_DONE    = 0;
  localparam int STS_FAULT   = 1;
  localparam int STS_REQ     = 2;
  localparam int STS_GATE_LO = 3;
  localparam int STS_STATE   = 4;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [3:0] CONTROL_RST = 4'h0;

  // ---------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------
  typedef enum logic [1:0] {
    FCC_IDLE    = 2'b00,
    FCC_RUN     = 2'b01,
    FCC_DONE    = 2'b10,
    FCC_FAULT   = 2'b11
  } fcc_state_t;

  typedef struct packed {
    logic charge_request;
    logic flash_permit;
    logic flash_trigger;
  } fcc_pins_t;

endpackage : fcc_pkg

// file: core/fcc_axil_slave.sv
/*
  AXI4-Lite slave with four word registers for the charger controller.
  Assumes write address and data may arrive in either order; one write
  and one read outstanding at a time.
*/
`timescale 1ns/1ps
module fcc_axil_slave
  import fcc_pkg::*;
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Write channels
  input  wire logic [3:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // Read channels
  input  wire logic [3:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // Register contents
  output logic [3:0]       control,
  output logic [31:0]      timeout,
  input  wire logic [31:0] status,
  input  wire logic [31:0] elapsed
);

  logic [3:0] wr_addr;
  logic       have_aw;
  logic       have_w;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;

  // ---------------------------------------------------------------------
  // Write path
  // ---------------------------------------------------------------------
  // Address and data are captured separately so either may come first.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      have_aw <= 1'b0;
      have_w  <= 1'b0;
      wr_addr <= 4'h0;
      wr_data <= 32'h0;
      wr_strb <= 4'h0;
      bvalid  <= 1'b0;
      bresp   <= RESP_OKAY;
      control <= CONTROL_RST;
      timeout <= CHARGE_TIMEOUT_DEF[31:0];
    end
    else
    begin
      if (awvalid && awready)
      begin
        have_aw <= 1'b1;
        wr_addr <= awaddr;
      end
      if (wvalid && wready)
      begin
        have_w  <= 1'b1;
        wr_data <= wdata;
        wr_strb <= wstrb;
      end
      if (have_aw && have_w && !bvalid)
      begin
        have_aw <= 1'b0;
        have_w  <= 1'b0;
        bvalid  <= 1'b1;
        bresp   <= RESP_OKAY;
        case (wr_addr)
          REG_CONTROL: if (wr_strb[0]) control <= wr_data[3:0];
          REG_TIMEOUT:
          begin
            for (int i = 0; i < 4; i++)
              if (wr_strb[i]) timeout[i*8 +: 8] <= wr_data[i*8 +: 8];
          end
          REG_STATUS, REG_ELAPSED: bresp <= RESP_OKAY;
          default: bresp <= RESP_SLVERR;
        endcase
      end
      else if (bvalid && bready)
        bvalid <= 1'b0;
    end
  end

  // Ready flags are registers so every bus output leaves a flop; a taken
  // channel closes at once and reopens when its response is taken.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready <= 1'b0;
      wready  <= 1'b0;
    end
    else
    begin
      awready <= awready ? !awvalid
                         : ((bvalid && bready) || (!bvalid && !have_aw));
      wready  <= wready ? !wvalid
                        : ((bvalid && bready) || (!bvalid && !have_w));
    end
  end

  // ---------------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------------
  // A read answers one cycle after the address is taken.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid <= 1'b0;
      rdata  <= 32'h0;
      rresp  <= RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      rvalid <= 1'b1;
      rresp  <= RESP_OKAY;
      case (araddr)
        REG_CONTROL: rdata <= {28'h0, control};
        REG_STATUS:  rdata <= status;
        REG_TIMEOUT: rdata <= timeout;
        REG_ELAPSED: rdata <= elapsed;
        default:
        begin
          rdata <= 32'h0;
          rresp <= RESP_SLVERR;
        end
      endcase
    end
    else if (rvalid && rready)
      rvalid <= 1'b0;
  end

  // The address channel closes on a take and reopens with the answer.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      arready <= 1'b0;
    else
      arready <= arready ? !arvalid : (rready || !rvalid);
  end

endmodule : fcc_axil_slave

// file: core/fcc_delay_line.sv
/*
  Shift delay for one level, used to hold the flash gate demand
  back by a fixed number of cycles. Assumes a synchronous input.
*/
`timescale 1ns/1ps
module fcc_delay_line #(
  parameter int DEPTH = 5
) (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Level in and out
  input  wire logic din,
  output logic      dout
);

  logic [DEPTH-1:0] taps;

  // Each stage passes the level on by one clock.
  genvar g;
  generate
    for (g = 0; g < DEPTH; g++)
    begin : g_stage
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
          taps[g] <= 1'b0;
        else if (g == 0)
          taps[g] <= din;
        else
          taps[g] <= taps[(g == 0) ? 0 : g-1];
      end
    end
  endgenerate

  assign dout = taps[DEPTH-1];

endmodule : fcc_delay_line

// file: verification/fcc_device_model.sv
/*
  Behavioural model of the flash charger device seen by the host block.
  Assumes the bench puts a pull-up on the completion line and drives the
  full, overcurrent, thermal and gate fault commands.
*/
`timescale 1ns/1ps
module fcc_device_model (
  // Host-driven pins
  input  wire charge_request,
  input  wire flash_permit,
  input  wire flash_trigger,
  // Bench commands for analog events
  input  wire full_cmd,
  input  wire ocp_cmd,
  input  wire tsd_cmd,
  input  wire gate_break,
  // Device outputs
  output wire charge_done_n,
  output wire flash_gate_drive
);
  // ---------------------------------------------------------------------
  // Charge sequencing
  // ---------------------------------------------------------------------
  logic en = 1'b0;
  logic done_low = 1'b0;
  logic trip = 1'b0;
  logic sw_on = 1'b0;

  always @(posedge charge_request)
  begin
    #150;
    if (charge_request)
      en = 1'b1;
  end

  always @(negedge charge_request)
  begin
    en = 1'b0;
    done_low = 1'b0;
    if (!ocp_cmd && !tsd_cmd)
      trip = 1'b0;
  end

  always @(posedge ocp_cmd)
    if (en)
      trip = 1'b1;

  always @(posedge tsd_cmd)
    trip = 1'b1;

  // full charge ends switching and disables
  always @(posedge full_cmd)
    if (en && !trip)
    begin
      done_low = 1'b1;
      en = 1'b0;
    end

  // fixed peak and zero crossing periods.
  always
  begin
    #40;
    sw_on = en && !trip && !done_low && !sw_on;
  end

  // open-drain, released while charging or tripped
  assign charge_done_n = done_low ? 1'b0 : 1'bz;

  // gate path; 26 ns keeps edges off the clock.
  assign #26 flash_gate_drive = !gate_break && flash_permit && flash_trigger;
endmodule : fcc_device_model

// file: verification/fcc_host_tb.sv
/*
  Self-checking bench of the flash charger host block over AXI4-Lite.
  Assumes the device model beside it and a small charge timeout.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) \
  begin miscompares++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module fcc_host_tb;
  import fcc_pkg::*;
  localparam int TMO = 200;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [3:0]  awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata, rd;
  logic        awready, wready, bvalid, arready, rvalid, gate;
  logic [1:0]  bresp, rresp, rs;
  logic        full_cmd, ocp_cmd, tsd_cmd, gate_break;
  fcc_pins_t   pins;
  tri1         done_n; // The pull-up on the open-drain line.
  int          miscompares, samples_checked, k;
  logic [31:0] tdef;

  // ---------------------------------------------------------------------
  // Clock, design and device
  // ---------------------------------------------------------------------
  initial
  begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  fcc_host #(.CHARGE_TIMEOUT(TMO)) dut_u (
    .aclk(aclk), .aresetn(aresetn),
    .s_axil_awaddr(awaddr), .s_axil_awvalid(awvalid),
    .s_axil_awready(awready), .s_axil_wdata(wdata), .s_axil_wstrb(wstrb),
    .s_axil_wvalid(wvalid), .s_axil_wready(wready), .s_axil_bresp(bresp),
    .s_axil_bvalid(bvalid), .s_axil_bready(bready),
    .s_axil_araddr(araddr), .s_axil_arvalid(arvalid),
    .s_axil_arready(arready), .s_axil_rdata(rdata), .s_axil_rresp(rresp),
    .s_axil_rvalid(rvalid), .s_axil_rready(rready),
    .pins(pins), .charge_done_n(done_n), .flash_gate_drive(gate));

  fcc_device_model dev_u (
    .charge_request(pins.charge_request), .flash_permit(pins.flash_permit),
    .flash_trigger(pins.flash_trigger), .full_cmd(full_cmd),
    .ocp_cmd(ocp_cmd), .tsd_cmd(tsd_cmd), .gate_break(gate_break),
    .charge_done_n(done_n), .flash_gate_drive(gate));

  // ---------------------------------------------------------------------
  // Bus tasks and helpers
  // ---------------------------------------------------------------------
  // Address and data are offered together and released as each is taken.
  task automatic wrr(input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    awaddr <= a; wdata <= d; wstrb <= s;
    awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    while (!(ad && wd))
    begin
      @(posedge aclk);
      if (awvalid && awready) begin ad = 1'b1; awvalid <= 1'b0; end
      if (wvalid && wready) begin wd = 1'b1; wvalid <= 1'b0; end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    rs = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask : wrr

  task automatic rdr(input logic [3:0] a);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask : rdr

  function automatic logic [31:0] sts(logic d, logic f, logic r,
                                      fcc_state_t s);
    return {26'h0, s, 1'b0, r, f, d};
  endfunction : sts

  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : finish_test

  // Cuts a hang short; the whole sequence needs under 3000 cycles.
  initial
  begin
    repeat (20000) @(posedge aclk);
    miscompares++;
    finish_test();
  end

  // ---------------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------------
  initial
  begin
    aresetn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0;
    arvalid = 1'b0; rready = 1'b0; awaddr = 4'h0; araddr = 4'h0;
    wstrb = 4'h0; wdata = 32'h0; full_cmd = 1'b0; ocp_cmd = 1'b0;
    tsd_cmd = 1'b0; gate_break = 1'b0;
    miscompares = 0; samples_checked = 0;
    tdef = 32'(CHARGE_TIMEOUT_DEF);
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    // Reset values, unmapped place and byte lanes.
    rdr(REG_CONTROL); `CHK(rd, {28'h0, CONTROL_RST})
    rdr(REG_TIMEOUT); `CHK(rd, tdef)
    rdr(REG_STATUS); `CHK(rd, sts(1'b0, 1'b0, 1'b0, FCC_IDLE))
    rdr(4'h2); `CHK(rs, RESP_SLVERR) `CHK(rd, 32'h0)
    wrr(4'h2, 32'h1, 4'hf); `CHK(rs, RESP_SLVERR)
    wrr(REG_TIMEOUT, 32'h123456ab, 4'h1); `CHK(rs, RESP_OKAY)
    rdr(REG_TIMEOUT); `CHK(rd, {tdef[31:8], 8'hab})
    // Overcurrent then thermal trip: no completion, fault by timing.
    for (k = 0; k < 2; k++)
    begin
      wrr(REG_CONTROL, 32'h1, 4'hf);
      repeat (40) @(posedge aclk);
      if (k == 0) ocp_cmd <= 1'b1; else tsd_cmd <= 1'b1;
      repeat (2) @(posedge aclk);
      full_cmd <= 1'b1;
      @(posedge aclk);
      full_cmd <= 1'b0;
      repeat (90) @(posedge aclk);
      rdr(REG_STATUS); `CHK(rd, sts(1'b0, 1'b0, 1'b1, FCC_RUN))
      `CHK(done_n, 1'b1)
      repeat (80) @(posedge aclk);
      rdr(REG_STATUS); `CHK(rd, sts(1'b0, 1'b1, 1'b1, FCC_FAULT))
      rdr(REG_ELAPSED); `CHK(rd, 32'(TMO))
      ocp_cmd <= 1'b0;
      tsd_cmd <= 1'b0;
      wrr(REG_CONTROL, 32'h0, 4'hf);
      repeat (3) @(posedge aclk);
      rdr(REG_STATUS); `CHK(rd, sts(1'b0, 1'b0, 1'b0, FCC_IDLE))
    end
    // Two full charges, the second a restart after the request is dropped from done.
    for (k = 0; k < 2; k++)
    begin
      wrr(REG_CONTROL, 32'h1, 4'hf);
      repeat (3) @(posedge aclk);
      `CHK(pins.charge_request, 1'b1)
      repeat (40) @(posedge aclk);
      `CHK(done_n, 1'b1)
      full_cmd <= 1'b1;
      @(posedge aclk);
      full_cmd <= 1'b0;
      do rdr(REG_STATUS); while (rd[STS_DONE] !== 1'b1);
      `CHK(rd, sts(1'b1, 1'b0, 1'b1, FCC_DONE))
      repeat (50) @(posedge aclk);
      `CHK(done_n, 1'b0)
      wrr(REG_CONTROL, 32'h0, 4'hf);
      repeat (3) @(posedge aclk);
      `CHK(pins.charge_request, 1'b0)
      `CHK(done_n, 1'b1)
      rdr(REG_STATUS); `CHK(rd, sts(1'b0, 1'b0, 1'b0, FCC_IDLE))
    end
    // Every permit, trigger and link combination.
    for (k = 0; k < 8; k++)
    begin
      wrr(REG_CONTROL, 32'(k << 1), 4'hf);
      repeat (10) @(posedge aclk);
      `CHK(pins.flash_trigger, k[2] ? k[0] : k[1])
      `CHK(pins.flash_permit, k[0])
      `CHK(gate, k[0] & (k[1] | k[2]))
      rdr(REG_STATUS); `CHK(rd[STS_GATE_LO], 1'b0)
    end
    // A gate that fails to follow leaves a sticky mark.
    gate_break <= 1'b1;
    wrr(REG_CONTROL, 32'h6, 4'hf);
    repeat (20) @(posedge aclk);
    gate_break <= 1'b0;
    wrr(REG_CONTROL, 32'h0, 4'hf);
    repeat (10) @(posedge aclk);
    rdr(REG_STATUS); `CHK(rd[STS_GATE_LO], 1'b1)
    finish_test();
  end
endmodule : fcc_host_tb
